// >>> verilog/ppc_consts.vh
// Purpose: constants for the pin pull-up, hi-z and interrupt-out control
// Assumes: 32-bit word-aligned register map, 16 live bits in the pull-up register, 4 in the others
// Notes:   definitions only
`ifndef PPC_CONSTS_VH
`define PPC_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PPC_OFS_PULLUP   6'h00
`define PPC_OFS_HIZ      6'h04
`define PPC_OFS_INTOUT   6'h08

// ----------------------------------------
// reset values
// ----------------------------------------
`define PPC_RST_PULLUP   16'h0000
`define PPC_RST_HIZ      4'hf
`define PPC_RST_INTOUT   4'h0

// ----------------------------------------
// hi-z keep bit positions
// ----------------------------------------
`define PPC_B_PORTD_UPPER 3
`define PPC_B_PORTD_LOWER 2
`define PPC_B_PORTE_UPPER 1
`define PPC_B_PORTE_LOWER 0

// ----------------------------------------
// pins covered by each strong-drive group
// ----------------------------------------
`define PPC_M_PD_UPPER   32'h3f00_0000
`define PPC_M_PD_LOWER   32'h0000_fc00
`define PPC_M_PE_UPPER   16'hfa00
`define PPC_M_PE_LOWER   16'h006f

// ----------------------------------------
// interrupt-out field positions and codes
// ----------------------------------------
`define PPC_F_PD_SEL_HI  3
`define PPC_F_PD_SEL_LO  2
`define PPC_F_PE_SEL_HI  1
`define PPC_F_PE_SEL_LO  0
`define PPC_IO_ACCEPT    2'h0
`define PPC_IO_REFRESH   2'h1
`define PPC_IO_STATE     2'h2
`define PPC_IO_HIGH      2'h3
`define PPC_MODE_INTOUT  3'h3

`endif

// >>> verilog/ppc_top.v
// Purpose: port E pull-up control, strong-drive hi-z forcing, interrupt-out
//          pin selection and multi-pin input/output function combining
// Assumes: all inputs synchronous to SYS_CLK; pin mode fields come from
//          the per-pin mode registers outside this block
// Notes:   pin-side effects are combinational from the register flops, so a
//          write shows on the pins from the cycle after its ack edge
//
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`include "ppc_consts.vh"

// ----------------------------------------
// multi-pin combine cell
// ----------------------------------------
// and type: unselected pins read as 1; or type: unselected pins read as 0
module ppc_combine #(
	parameter NP       = 4,
	parameter AND_TYPE = 0
) (
	input  wire [NP-1:0] pin_lvl, // pin levels
	input  wire [NP-1:0] pin_sel, // pins assigned to the function
	output wire          func_out // merged internal signal
);
	// masked reduce of the assigned pins
	assign func_out = AND_TYPE ? &(pin_lvl | ~pin_sel) : |(pin_lvl & pin_sel);
endmodule // ppc_combine

module ppc_top #(
	parameter NP  = 4, // pins a shared function may use
	parameter NOR = 4, // or-type input functions
	parameter NAN = 4, // and-type input functions
	parameter NFO = 2, // shared output functions
	parameter NED = 4  // edge-detect function pins
) (
	input  wire                 SYS_CLK,         // system clock 100 MHz
	input  wire                 RST_N,           // async reset, active low
	input  wire                 WB_CYC_I,        // bus cycle
	input  wire                 WB_STB_I,        // bus strobe
	input  wire                 WB_WE_I,         // write enable
	input  wire [5:0]           WB_ADR_I,        // byte address
	input  wire [3:0]           WB_SEL_I,        // byte lanes
	input  wire [31:0]          WB_DAT_I,        // write data
	output wire [31:0]          WB_DAT_O,        // read data
	output wire                 WB_ACK_O,        // acknowledge
	input  wire                 POR_BUSY,        // power-on reset in progress
	input  wire [15:0]          PE_PIN_OUT,      // port E pin driving output
	input  wire [15:0]          PE_PU_CAPABLE,   // function allows pull-up
	output wire [15:0]          PE_PULLUP_ON,    // pull-up device enables
	input  wire                 OSC_STOP_DET,    // oscillation stop detected
	input  wire                 SW_STANDBY,      // software standby mode
	input  wire [31:0]          PD_OE_IN,        // port D enables from mux
	input  wire [15:0]          PE_OE_IN,        // port E enables from mux
	output wire [31:0]          PD_OE,           // port D enables to pads
	output wire [15:0]          PE_OE,           // port E enables to pads
	input  wire [2:0]           PORTD_PIN30_MODE, // port D pin 30 mode field
	input  wire [2:0]           PORTE_PIN15_MODE, // port E pin 15 mode field
	input  wire                 INT_ACCEPT_N,    // interrupt accept, low act
	input  wire                 REFRESH_REQ_N,   // refresh request, low act
	input  wire                 REFRESH_PHASE,   // state picks refresh
	output wire                 PD30_INTOUT_N,   // port D pin 30 level
	output wire                 PE15_INTOUT_N,   // port E pin 15 level
	input  wire [NOR*NP-1:0]    OR_PIN_LVL,      // or-type pin levels
	input  wire [NOR*NP-1:0]    OR_PIN_SEL,      // or-type assignments
	output wire [NOR-1:0]       OR_FUNC_IN,      // or-merged functions
	input  wire [NAN*NP-1:0]    AND_PIN_LVL,     // and-type pin levels
	input  wire [NAN*NP-1:0]    AND_PIN_SEL,     // and-type assignments
	output wire [NAN-1:0]       AND_FUNC_IN,     // and-merged functions
	input  wire [NFO-1:0]       FO_SRC,          // shared output sources
	input  wire [NFO*NP-1:0]    FO_PIN_SEL,      // output assignments
	output wire [NFO*NP-1:0]    FO_PIN_DRV,      // per pin per function drive
	input  wire [NED-1:0]       EDGE_PIN_LVL,    // edge-capable pin levels
	input  wire [NED-1:0]       EDGE_FUNC_SEL,   // 1: edge function chosen
	output wire [NED-1:0]       EDGE_FUNC_LVL,   // level seen by detector
	output wire [NED-1:0]       EDGE_FALL        // falling edge, one cycle
);

	// ----------------------------------------
	// register file state
	// ----------------------------------------
	reg  [15:0]   pullup_q;
	reg  [3:0]    hiz_keep_q;
	reg  [3:0]    intout_q;
	reg           ack_q;
	reg  [31:0]   rdat_q;
	reg  [31:0]   rdat_d;
	reg  [NED-1:0] edge_prev_q;
	reg  [NED-1:0] edge_fall_q;

	wire          req;
	wire          wr_commit;
	wire          hit_pullup;
	wire          hit_hiz;
	wire          hit_intout;
	wire [5:0]    adr_word;
	wire          wr_pu_lo;
	wire          wr_pu_hi;
	wire          wr_hiz;
	wire          wr_io;

	// ----------------------------------------
	// wishbone decode
	// ----------------------------------------
	// request qualified; writes land only on the ack edge
	assign req        = WB_CYC_I & WB_STB_I;
	assign wr_commit  = req & WB_WE_I & ack_q;
	// word address kept at full width so it meets the offsets bit for bit
	assign adr_word   = WB_ADR_I & 6'h3c;
	assign hit_pullup = (adr_word == `PPC_OFS_PULLUP);
	assign hit_hiz    = (adr_word == `PPC_OFS_HIZ);
	assign hit_intout = (adr_word == `PPC_OFS_INTOUT);

	// per-register lane strobes; the 4-bit registers sit in lane 0 only
	assign wr_pu_lo   = wr_commit & hit_pullup & WB_SEL_I[0];
	assign wr_pu_hi   = wr_commit & hit_pullup & WB_SEL_I[1];
	assign wr_hiz     = wr_commit & hit_hiz & WB_SEL_I[0];
	assign wr_io      = wr_commit & hit_intout & WB_SEL_I[0];

	// one-wait-state ack, dropped the cycle after it was given
	// the wait state lets the read mux settle from the decoded address
	// before the data is latched, at the cost of one cycle per access
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	// read mux; unmapped offsets read zero and still ack
	always @*
	begin
		rdat_d = 32'h0000_0000;
		if (hit_pullup)
			rdat_d = {16'h0000, pullup_q};
		else if (hit_hiz)
			rdat_d = {28'h000_0000, hiz_keep_q};
		else if (hit_intout)
			rdat_d = {28'h000_0000, intout_q};
	end

	// read data captured as ack rises so it is stable with it
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
			rdat_q <= 32'h0000_0000;
		else if (req & ~ack_q)
			rdat_q <= rdat_d;
	end

	assign WB_ACK_O = ack_q;
	assign WB_DAT_O = rdat_q;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	// byte lanes honoured; upper reserved bits are simply not stored
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			pullup_q   <= `PPC_RST_PULLUP;
			hiz_keep_q <= `PPC_RST_HIZ;
			intout_q   <= `PPC_RST_INTOUT;
		end
		else
		begin
			if (wr_pu_lo)
				pullup_q[7:0] <= WB_DAT_I[7:0];
			if (wr_pu_hi)
				pullup_q[15:8] <= WB_DAT_I[15:8];
			if (wr_hiz)
				hiz_keep_q <= WB_DAT_I[3:0];
			if (wr_io)
				intout_q <= WB_DAT_I[3:0];
		end
	end

	// ----------------------------------------
	// port E pull-up gating
	// ----------------------------------------
	wire [15:0] pu_allowed;
	wire        pu_hold_off;

	// bus reset counts as power-on here: the register is not yet valid,
	// and a pull-up fighting an external driver must be avoided
	// off during power-on
	assign pu_hold_off = POR_BUSY | ~RST_N;

	// combinational on direction, so a serial pin turning round sees its
	// pull-up follow in the same cycle with no stale state held here
	// input or hi-z only
	assign pu_allowed  = PE_PU_CAPABLE & ~PE_PIN_OUT;

	assign PE_PULLUP_ON = pu_hold_off ? 16'h0000 : (pullup_q & pu_allowed);

	// ----------------------------------------
	// strong-drive hi-z forcing
	// ----------------------------------------
	wire        hiz_cond;
	wire        frc_pd_upper;
	wire        frc_pd_lower;
	wire        frc_pe_upper;
	wire        frc_pe_lower;
	wire [31:0] pd_force;
	wire [15:0] pe_force;

	// forcing only in stop detection or standby
	assign hiz_cond = OSC_STOP_DET | SW_STANDBY;

	// a group floats only while stopped and its keep bit is clear
	// port D upper group
	assign frc_pd_upper = hiz_cond & ~hiz_keep_q[`PPC_B_PORTD_UPPER];
	assign frc_pd_lower = hiz_cond & ~hiz_keep_q[`PPC_B_PORTD_LOWER];
	assign frc_pe_upper = hiz_cond & ~hiz_keep_q[`PPC_B_PORTE_UPPER];
	assign frc_pe_lower = hiz_cond & ~hiz_keep_q[`PPC_B_PORTE_LOWER];

	// group masks widened to the port; pins outside every group never float
	assign pd_force = ({32{frc_pd_upper}} & `PPC_M_PD_UPPER) |
	                  ({32{frc_pd_lower}} & `PPC_M_PD_LOWER);
	assign pe_force = ({16{frc_pe_upper}} & `PPC_M_PE_UPPER) |
	                  ({16{frc_pe_lower}} & `PPC_M_PE_LOWER);

	// override wins over the function mux; kept groups pass through, so a
	// pin driving at the stop keeps driving the same level
	// keep passes state
	assign PD_OE = PD_OE_IN & ~pd_force;
	assign PE_OE = PE_OE_IN & ~pe_force;

	// ----------------------------------------
	// interrupt-out pin selection
	// ----------------------------------------
	reg  pd_intout_lvl;
	reg  pe_intout_lvl;
	wire [1:0] pd_sel;
	wire [1:0] pe_sel;
	wire       pd_mode_io;
	wire       pe_mode_io;

	assign pd_sel = {intout_q[`PPC_F_PD_SEL_HI], intout_q[`PPC_F_PD_SEL_LO]};
	assign pe_sel = {intout_q[`PPC_F_PE_SEL_HI], intout_q[`PPC_F_PE_SEL_LO]};

	// mode compare done once per pin, each gating only its own pin
	assign pd_mode_io = (PORTD_PIN30_MODE == `PPC_MODE_INTOUT);
	assign pe_mode_io = (PORTE_PIN15_MODE == `PPC_MODE_INTOUT);

	// shared decode for both pins
	function sel_level;
		input [1:0] code;
		input       acc_n;
		input       ref_n;
		input       phase;
		begin
			case (code)
				`PPC_IO_ACCEPT:  sel_level = acc_n;
				`PPC_IO_REFRESH: sel_level = ref_n;
				`PPC_IO_STATE:   sel_level = phase ? ref_n : acc_n;
				`PPC_IO_HIGH:    sel_level = 1'b1;
				default:         sel_level = 1'b1;
			endcase
		end
	endfunction

	// pins idle high when another function owns them
	// the output is active low, so high is the harmless level for a board
	always @*
	begin
		if (pd_mode_io)
			pd_intout_lvl = sel_level(pd_sel, INT_ACCEPT_N, REFRESH_REQ_N,
			                          REFRESH_PHASE);
		else
			pd_intout_lvl = 1'b1;
		if (pe_mode_io)
			pe_intout_lvl = sel_level(pe_sel, INT_ACCEPT_N, REFRESH_REQ_N,
			                          REFRESH_PHASE);
		else
			pe_intout_lvl = 1'b1;
	end

	assign PD30_INTOUT_N = pd_intout_lvl;
	assign PE15_INTOUT_N = pe_intout_lvl;

	// ----------------------------------------
	// multi-pin function combining
	// ----------------------------------------
	// undefined mode codes are not screened here; behaviour then follows
	// whatever the assignment vectors carry
	// defined codes assumed
	genvar gi;
	generate
		for (gi = 0; gi < NOR; gi = gi + 1)
		begin : g_or
			ppc_combine #(
				.NP       (NP),
				.AND_TYPE (0)
			) u_or (
				.pin_lvl  (OR_PIN_LVL[gi*NP +: NP]),
				.pin_sel  (OR_PIN_SEL[gi*NP +: NP]),
				.func_out (OR_FUNC_IN[gi])
			);
		end
		for (gi = 0; gi < NAN; gi = gi + 1)
		begin : g_and
			ppc_combine #(
				.NP       (NP),
				.AND_TYPE (1)
			) u_and (
				.pin_lvl  (AND_PIN_LVL[gi*NP +: NP]),
				.pin_sel  (AND_PIN_SEL[gi*NP +: NP]),
				.func_out (AND_FUNC_IN[gi])
			);
		end
		for (gi = 0; gi < NFO; gi = gi + 1)
		begin : g_fo
			assign FO_PIN_DRV[gi*NP +: NP] = FO_PIN_SEL[gi*NP +: NP] &
			                                 {NP{FO_SRC[gi]}};
		end
	endgenerate

	// ----------------------------------------
	// edge functions on shared port pins
	// ----------------------------------------
	// while the pin is a port the detector sees an idle high level, so a
	// pin sitting low at the switch shows as a falling edge, as it must
	wire [NED-1:0] edge_lvl;

	assign edge_lvl      = EDGE_PIN_LVL | ~EDGE_FUNC_SEL;
	assign EDGE_FUNC_LVL = edge_lvl;

	// previous level; reset idle high so release makes no edge unless a selected pin is low
	// limitation: a pin switched while high shows no edge until it later
	// falls, exactly as an ordinary falling edge would
	always @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			edge_prev_q <= {NED{1'b1}};
			edge_fall_q <= {NED{1'b0}};
		end
		else
		begin
			edge_prev_q <= edge_lvl;
			edge_fall_q <= edge_prev_q & ~edge_lvl;
		end
	end

	assign EDGE_FALL = edge_fall_q;

endmodule // ppc_top

// >>> testbench/ppc_chk.sv
// Purpose: port-level assertions for the pin control block
// Assumes: register shadows follow bus writes at the ack edge
// Notes:   bound into ppc_top at the foot of this file
`timescale 1ns/100ps
`include "ppc_consts.vh"
module ppc_chk #(
	parameter NED = 4
) (
	input wire            SYS_CLK,          // clock
	input wire            RST_N,            // reset, active low
	input wire            WB_CYC_I,         // bus cycle
	input wire            WB_STB_I,         // bus strobe
	input wire            WB_WE_I,          // write
	input wire [5:0]      WB_ADR_I,         // address
	input wire [3:0]      WB_SEL_I,         // lanes
	input wire [31:0]     WB_DAT_I,         // write data
	input wire [31:0]     WB_DAT_O,         // read data
	input wire            WB_ACK_O,         // ack
	input wire            POR_BUSY,         // power-on reset
	input wire [15:0]     PE_PIN_OUT,       // pin driving
	input wire [15:0]     PE_PU_CAPABLE,    // pull-up allowed
	input wire [15:0]     PE_PULLUP_ON,     // pull-ups
	input wire            OSC_STOP_DET,     // osc stop
	input wire            SW_STANDBY,       // standby
	input wire [31:0]     PD_OE_IN,         // mux enables
	input wire [31:0]     PD_OE,            // pad enables
	input wire [2:0]      PORTD_PIN30_MODE, // mode field
	input wire            INT_ACCEPT_N,     // accept source
	input wire            REFRESH_REQ_N,    // refresh source
	input wire            REFRESH_PHASE,    // state select
	input wire            PD30_INTOUT_N,    // pin level
	input wire [NED-1:0]  EDGE_FUNC_LVL,    // detector level
	input wire [NED-1:0]  EDGE_FALL         // edge pulse
);
// ----------------------------------------
// register shadows
// ----------------------------------------
reg  [15:0] pu_q;
reg  [3:0]  hz_q;
reg  [3:0]  io_q;
wire        wr   = WB_ACK_O & WB_CYC_I & WB_STB_I & WB_WE_I;
wire        stop = OSC_STOP_DET | SW_STANDBY;
wire [31:0] pd_kill = {32{stop}} & ((hz_q[3] ? 32'h0 : `PPC_M_PD_UPPER) |
	(hz_q[2] ? 32'h0 : `PPC_M_PD_LOWER));
wire        use_ref = io_q[3] ? REFRESH_PHASE : io_q[2];
wire        pd30_exp = (io_q[3:2] == 2'h3) | (use_ref ? REFRESH_REQ_N : INT_ACCEPT_N);

// shadows copy writes so pins can be judged without peeking inside
always @(posedge SYS_CLK or negedge RST_N)
begin
	if (!RST_N)
	begin
		pu_q <= 16'h0000;
		hz_q <= 4'hf;
		io_q <= 4'h0;
	end
	else
	begin
		if (wr && WB_SEL_I[0] && WB_ADR_I[5:2] == 4'h0)
			pu_q[7:0] <= WB_DAT_I[7:0];
		if (wr && WB_SEL_I[1] && WB_ADR_I[5:2] == 4'h0)
			pu_q[15:8] <= WB_DAT_I[15:8];
		if (wr && WB_SEL_I[0] && WB_ADR_I[5:2] == 4'h1)
			hz_q <= WB_DAT_I[3:0];
		if (wr && WB_SEL_I[0] && WB_ADR_I[5:2] == 4'h2)
			io_q <= WB_DAT_I[3:0];
	end
end

// ----------------------------------------
// properties
// ----------------------------------------
default clocking cb @(posedge SYS_CLK); endclocking
default disable iff (!RST_N);
AST_ACK_WAIT: assert property ($rose(WB_CYC_I && WB_STB_I) |=> WB_ACK_O)
	else $error("ack not one cycle after request");
AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
	else $error("ack longer than one cycle");
AST_PULLUP: assert property (PE_PULLUP_ON == (pu_q & ~PE_PIN_OUT & PE_PU_CAPABLE & {16{!POR_BUSY}}))
	else $error("pull-up enables wrong");
AST_HIZ_PD: assert property (PD_OE == (PD_OE_IN & ~pd_kill))
	else $error("port d enables wrong");
AST_RSV_RD: assert property (WB_ACK_O && !WB_WE_I && WB_ADR_I[5:2] != 4'h0 |-> WB_DAT_O[31:4] == 28'h0)
	else $error("reserved bits read nonzero");
AST_PD30_OFF: assert property (PORTD_PIN30_MODE != `PPC_MODE_INTOUT |-> PD30_INTOUT_N)
	else $error("pin 30 driven outside its mode");
AST_PD30_SEL: assert property (PORTD_PIN30_MODE == `PPC_MODE_INTOUT |-> PD30_INTOUT_N == pd30_exp)
	else $error("pin 30 source wrong");
AST_EDGE: assert property ($fell(EDGE_FUNC_LVL[0]) |=> EDGE_FALL[0])
	else $error("falling edge missed");
cover property (stop && hz_q != 4'hf);
cover property (WB_ACK_O && !WB_WE_I);
cover property (EDGE_FALL[0]);
endmodule // ppc_chk

bind ppc_top ppc_chk #(.NED(NED)) i_ppc_chk (.SYS_CLK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
	.WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .POR_BUSY, .PE_PIN_OUT,
	.PE_PU_CAPABLE, .PE_PULLUP_ON, .OSC_STOP_DET, .SW_STANDBY, .PD_OE_IN, .PD_OE,
	.PORTD_PIN30_MODE, .INT_ACCEPT_N, .REFRESH_REQ_N, .REFRESH_PHASE, .PD30_INTOUT_N,
	.EDGE_FUNC_LVL, .EDGE_FALL);

// >>> testbench/ppc_brd.sv
// Purpose: board-side sources for the interrupt-out pins
// Assumes: one clock, same as the block
// Notes:   accept source toggles every cycle, refresh every second cycle, so a wrong select shows
`timescale 1ns/100ps
module ppc_brd (
	input  wire clk,   // clock
	input  wire rst_n, // reset, active low
	output wire acc_n, // accept source
	output wire ref_n  // refresh source
);
reg [1:0] cnt_q;
// free count walks through all four source pairs
always @(posedge clk or negedge rst_n)
begin
	if (!rst_n)
		cnt_q <= 2'h0;
	else
		cnt_q <= cnt_q + 2'h1;
end
assign acc_n = cnt_q[0];
assign ref_n = cnt_q[1];
endmodule // ppc_brd

// >>> testbench/tb_top.sv
// Purpose: self-checking bench for the pin control block
// Assumes: one wait-state bus answer, 100 MHz clock
// Notes:   outputs compared at the edge after inputs move
`timescale 1ns/100ps
`include "ppc_consts.vh"
module tb_top;
typedef struct {logic [5:0] a; logic [31:0] d; logic [31:0] q;} ppc_row_t;
logic        SYS_CLK = 1'b0, RST_N = 1'b0, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
logic        POR_BUSY = 1'b0, OSC_STOP_DET = 1'b0, SW_STANDBY = 1'b0, REFRESH_PHASE = 1'b0;
logic        WB_ACK_O, PD30_INTOUT_N, PE15_INTOUT_N, acc_n, ref_n;
logic [5:0]  WB_ADR_I = 6'h00;
logic [3:0]  WB_SEL_I = 4'hf, EDGE_PIN_LVL = 4'hf, EDGE_FUNC_SEL = 4'h0, h;
logic [3:0]  OR_FUNC_IN, AND_FUNC_IN, EDGE_FUNC_LVL, EDGE_FALL;
logic [31:0] WB_DAT_I = 32'h0, PD_OE_IN = 32'hffff_ffff, WB_DAT_O, PD_OE, rd, pk;
logic [15:0] PE_PIN_OUT = 16'h0, PE_PU_CAPABLE = 16'hffff, PE_OE_IN = 16'hffff, PE_PULLUP_ON;
logic [15:0] OR_PIN_LVL = 16'h0, OR_PIN_SEL = 16'h0, AND_PIN_LVL = 16'h0, AND_PIN_SEL = 16'h0;
logic [15:0] PE_OE, ek;
logic [2:0]  PORTD_PIN30_MODE = 3'h0, PORTE_PIN15_MODE = 3'h0;
logic [1:0]  FO_SRC = 2'h0, c;
logic [7:0]  FO_PIN_SEL = 8'h0, FO_PIN_DRV;
int          miscompares = 0, n_checks = 0, cycles = 0;
// address, write data, readback: reserved bits written one read back zero, unmapped reads zero
ppc_row_t    rows [4] = '{'{6'h00, 32'hffff_a5c3, 32'ha5c3}, '{6'h04, 32'h0000_0005, 32'h5},
	'{6'h08, 32'h0000_0006, 32'h6}, '{6'h0c, 32'hffff_ffff, 32'h0}};

ppc_top i_ppc_top (.SYS_CLK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I,
	.WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .POR_BUSY, .PE_PIN_OUT, .PE_PU_CAPABLE, .PE_PULLUP_ON,
	.OSC_STOP_DET, .SW_STANDBY, .PD_OE_IN, .PE_OE_IN, .PD_OE, .PE_OE, .PORTD_PIN30_MODE,
	.PORTE_PIN15_MODE, .INT_ACCEPT_N(acc_n), .REFRESH_REQ_N(ref_n), .REFRESH_PHASE,
	.PD30_INTOUT_N, .PE15_INTOUT_N, .OR_PIN_LVL, .OR_PIN_SEL, .OR_FUNC_IN, .AND_PIN_LVL,
	.AND_PIN_SEL, .AND_FUNC_IN, .FO_SRC, .FO_PIN_SEL, .FO_PIN_DRV, .EDGE_PIN_LVL,
	.EDGE_FUNC_SEL, .EDGE_FUNC_LVL, .EDGE_FALL);
ppc_brd i_ppc_brd (.clk(SYS_CLK), .rst_n(RST_N), .acc_n, .ref_n);

always #5 SYS_CLK = ~SYS_CLK;

// hang guard, far beyond the 150 or so cycles the run needs
always @(posedge SYS_CLK)
begin
	cycles++;
	if (cycles == 3000)
	begin
		miscompares++;
		report_and_stop;
	end
end

task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
	n_checks++;
	if (got !== exp)
	begin
		miscompares++;
		$display("FAIL %s exp %h got %h", nm, exp, got);
	end
endtask

// one classic cycle; waits on ack, then idles one cycle
task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
	int n;
	n = 0;
	WB_CYC_I <= 1'b1;
	WB_STB_I <= 1'b1;
	WB_WE_I <= we;
	WB_ADR_I <= a;
	WB_DAT_I <= d;
	do
	begin
		@(posedge SYS_CLK);
		n++;
	end
	while (WB_ACK_O !== 1'b1);
	chk("ack wait", 32'h2, n);
	rd = WB_DAT_O;
	WB_CYC_I <= 1'b0;
	WB_STB_I <= 1'b0;
	@(posedge SYS_CLK);
endtask

function automatic logic sel_exp(input logic [1:0] k);
	sel_exp = (k == 2'h3) | ((k == 2'h1 || (k == 2'h2 && REFRESH_PHASE)) ? ref_n : acc_n);
endfunction

task report_and_stop;
	if (miscompares == 0 && n_checks > 0)
		$display("NO MISMATCHES");
	else
		$display("MISMATCHES SEEN");
	$finish;
endtask

initial
begin
	repeat (6) @(posedge SYS_CLK);
	RST_N <= 1'b1;
	@(posedge SYS_CLK);
	foreach (rows[i])
	begin
		bus(1'b1, rows[i].a, rows[i].d);
		bus(1'b0, rows[i].a, 32'h0);
		chk("readback", rows[i].q, rd);
	end
	// pull-up gating: direction, capability, power-on
	PE_PIN_OUT <= 16'h00ff;
	PE_PU_CAPABLE <= 16'hf0f0;
	@(posedge SYS_CLK);
	chk("pullup", 32'ha000, {16'h0, PE_PULLUP_ON});
	PE_PIN_OUT <= 16'hff00;
	@(posedge SYS_CLK);
	chk("pullup dir", 32'h00c0, {16'h0, PE_PULLUP_ON});
	POR_BUSY <= 1'b1;
	@(posedge SYS_CLK);
	chk("pullup por", 32'h0, {16'h0, PE_PULLUP_ON});
	POR_BUSY <= 1'b0;
	// group keep bits against stop and standby
	for (int i = 0; i < 8; i++)
	begin
		h = 4'(i * 5);
		bus(1'b1, `PPC_OFS_HIZ, {28'h0, h});
		{OSC_STOP_DET, SW_STANDBY} <= i[1:0];
		@(posedge SYS_CLK);
		pk = (h[3] ? 32'h0 : `PPC_M_PD_UPPER) | (h[2] ? 32'h0 : `PPC_M_PD_LOWER);
		ek = (h[1] ? 16'h0 : `PPC_M_PE_UPPER) | (h[0] ? 16'h0 : `PPC_M_PE_LOWER);
		chk("pd_oe", ~({32{|i[1:0]}} & pk), PD_OE);
		chk("pe_oe", {16'h0, ~({16{|i[1:0]}} & ek)}, {16'h0, PE_OE});
	end
	// every select code in both states, both pins
	// defined codes only
	PORTD_PIN30_MODE <= `PPC_MODE_INTOUT;
	PORTE_PIN15_MODE <= `PPC_MODE_INTOUT;
	for (int i = 0; i < 8; i++)
	begin
		c = i[2:1];
		REFRESH_PHASE <= i[0];
		bus(1'b1, `PPC_OFS_INTOUT, {28'h0, c, ~c});
		repeat (4)
		begin
			@(posedge SYS_CLK);
			chk("pd30", {31'h0, sel_exp(c)}, {31'h0, PD30_INTOUT_N});
			chk("pe15", {31'h0, sel_exp(~c)}, {31'h0, PE15_INTOUT_N});
		end
	end
	PORTE_PIN15_MODE <= 3'h0;
	@(posedge SYS_CLK);
	chk("pe15 off", 32'h1, {31'h0, PE15_INTOUT_N});
	// shared inputs and outputs
	OR_PIN_SEL <= 16'h0006;
	OR_PIN_LVL <= 16'h0004;
	AND_PIN_SEL <= 16'h0006;
	AND_PIN_LVL <= 16'h000b;
	FO_SRC <= 2'h2;
	FO_PIN_SEL <= 8'h3c;
	@(posedge SYS_CLK);
	chk("or", 32'h1, {28'h0, OR_FUNC_IN});
	chk("and", 32'he, {28'h0, AND_FUNC_IN});
	chk("fo", 32'h30, {24'h0, FO_PIN_DRV});
	OR_PIN_LVL <= 16'h0009;
	AND_PIN_LVL <= 16'h0006;
	@(posedge SYS_CLK);
	chk("or2", 32'h0, {28'h0, OR_FUNC_IN});
	chk("and2", 32'hf, {28'h0, AND_FUNC_IN});
	// low port pin switched to edge function
	EDGE_PIN_LVL <= 4'h0;
	@(posedge SYS_CLK);
	EDGE_FUNC_SEL <= 4'h1;
	@(posedge SYS_CLK);
	chk("edge lvl", 32'he, {28'h0, EDGE_FUNC_LVL});
	@(posedge SYS_CLK);
	chk("edge", 32'h1, {28'h0, EDGE_FALL});
	// back-to-back writes, upper lane only on the second
	bus(1'b1, `PPC_OFS_PULLUP, 32'h1234);
	WB_SEL_I <= 4'h2;
	bus(1'b1, `PPC_OFS_PULLUP, 32'hffff);
	WB_SEL_I <= 4'hf;
	bus(1'b0, `PPC_OFS_PULLUP, 32'h0);
	chk("lanes", 32'hff34, rd);
	// mid-run reset returns reset values
	RST_N <= 1'b0;
	repeat (2) @(posedge SYS_CLK);
	RST_N <= 1'b1;
	@(posedge SYS_CLK);
	for (int i = 0; i < 3; i++)
	begin
		bus(1'b0, 6'(i * 4), 32'h0);
		chk("reset val", (i == 1) ? 32'hf : 32'h0, rd);
	end
	report_and_stop;
end
endmodule // tb_top
